//--- common/sst_pkg.sv
// Purpose: Shared constants and types for the skip, subtract, swap, table-read and XOR execution core.
// Assumes: 8-bit data path, 16-bit program words, one clock.
// Notes: Offsets are byte addresses on the plain register port.
package sst_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] REG_ACC = 8'h40;
  localparam logic [7:0] REG_STATUS = 8'h41;
  localparam logic [7:0] REG_TABLE_POINTER_LOW = 8'h42;
  localparam logic [7:0] REG_TABLE_POINTER_HIGH = 8'h43;
  localparam logic [7:0] REG_TABLE_HIGH_LATCH = 8'h44;

  // ****************************************
  // Status field positions and reset values
  // ****************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;
  localparam int FLAG_CZ = 5;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_STATUS = 6'h00;
  localparam logic [7:0] LAST_PAGE = 8'hFF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    SST_INCREMENT_SKIP_ZERO, SST_INCREMENT_TO_ACCUM_SKIP_ZERO, SST_SKIP_NONZERO, SST_SKIP_NONZERO_BIT,
    SST_SKIP_IF_ZERO, SST_SKIP_IF_ZERO_BIT, SST_COPY_AND_SKIP_ZERO, SST_SUB, SST_MINUS_INTO_MEMORY,
    SST_SUB_IMM, SST_NIBBLE_EXCHANGE, SST_NIBBLE_EXCHANGE_TO_ACCUM, SST_TABLE_READ_PAGED,
    SST_TABLE_READ_LAST_PAGE, SST_PREINCREMENT_TABLE_READ, SST_PREINCREMENT_TABLE_READ_LAST,
    SST_XOR, SST_XOR_INTO_MEMORY, SST_XOR_IMM
  } sst_op_type;

  typedef enum logic [2:0] {
    SST_IDLE = 3'b001,
    SST_DUMMY = 3'b010,
    SST_TABLE = 3'b100
  } sst_fsm_type;

  typedef struct packed {
    sst_op_type op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } sst_instr_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sst_bus_type;

endpackage : sst_pkg

//--- verilog/sst_exec.sv
// Purpose: Executes one group of 8-bit instructions against internal data memory and external program memory.
// Assumes: Program memory answers combinationally in the cycle its address is driven.
// Notes: Registers and data memory are reachable over the plain register port.
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps

module sst_exec #(
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ins_valid,
  input wire sst_pkg::sst_instr_type ins,
  input wire sst_pkg::sst_bus_type bus,
  output logic [7:0] rdata,
  output logic [15:0] prog_addr,
  output logic prog_rd,
  input wire logic [15:0] prog_data,
  output logic busy,
  output logic done,
  output logic skip_taken
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [7:0] MEM_TOP = 8'(DEPTH);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    sst_pkg::sst_fsm_type fsm;
    logic [7:0] acc;
    logic [5:0] status;
    logic [7:0] table_pointer_low;
    logic [7:0] table_pointer_high;
    logic [7:0] table_high_latch;
    logic [AW-1:0] dst;
    logic [DEPTH-1:0][7:0] mem;
    logic [7:0] rdata;
    logic [15:0] prog_addr;
    logic prog_rd;
    logic busy;
    logic done;
    logic skip;
  } sst_state_type;

  sst_state_type s_reg;
  sst_state_type s_next;

  logic take;
  logic [AW-1:0] idx;
  logic [7:0] opnd;
  logic [7:0] opnd_swap;
  logic opnd_bit;
  logic [7:0] acc_minus;
  logic [7:0] xor_val;

  assign take = ins_valid && (s_reg.fsm == sst_pkg::SST_IDLE);
  assign idx = ins.addr[AW-1:0];
  assign opnd = s_reg.mem[idx];
  assign opnd_swap = {opnd[3:0], opnd[7:4]};
  assign opnd_bit = opnd[ins.bit_sel];
  assign acc_minus = s_reg.acc - opnd;
  assign xor_val = s_reg.acc ^ opnd;

  // Returns {flags, result}; flags laid out as in the status register.
  function automatic logic [13:0] sub_f(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d;
    logic [4:0] h;
    logic [5:0] f;
    d = {1'b0, a} - {1'b0, b};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    f = sst_pkg::RST_STATUS;
    f[sst_pkg::FLAG_C] = ~d[8];
    f[sst_pkg::FLAG_AC] = ~h[4];
    f[sst_pkg::FLAG_Z] = (d[7:0] == sst_pkg::ZERO_BYTE);
    f[sst_pkg::FLAG_OV] = (a[7] != b[7]) && (d[7] != a[7]);
    f[sst_pkg::FLAG_SC] = d[7] ^ f[sst_pkg::FLAG_OV];
    // With no incoming carry the chained zero matches the plain zero.
    f[sst_pkg::FLAG_CZ] = f[sst_pkg::FLAG_Z];
    return {f, d[7:0]};
  endfunction : sub_f

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic do_skip;
    logic is_tab;
    logic [13:0] sr;
    logic [7:0] tp;
    do_skip = 1'b0;
    is_tab = 1'b0;
    sr = sub_f(s_reg.acc, opnd);
    tp = s_reg.table_pointer_low;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.skip = 1'b0;
    s_next.prog_rd = 1'b0;
    s_next.rdata = sst_pkg::ZERO_BYTE;

    if (bus.rd) begin
      if (bus.addr < MEM_TOP) begin
        s_next.rdata = s_reg.mem[bus.addr[AW-1:0]];
      end else if (bus.addr == sst_pkg::REG_ACC) begin
        s_next.rdata = s_reg.acc;
      end else if (bus.addr == sst_pkg::REG_STATUS) begin
        s_next.rdata = {2'b00, s_reg.status};
      end else if (bus.addr == sst_pkg::REG_TABLE_POINTER_LOW) begin
        s_next.rdata = s_reg.table_pointer_low;
      end else if (bus.addr == sst_pkg::REG_TABLE_POINTER_HIGH) begin
        s_next.rdata = s_reg.table_pointer_high;
      end else if (bus.addr == sst_pkg::REG_TABLE_HIGH_LATCH) begin
        s_next.rdata = s_reg.table_high_latch;
      end
    end

    // A software write lands first so that an instruction in the same cycle has the final word.
    if (bus.wr) begin
      if (bus.addr < MEM_TOP) begin
        s_next.mem[bus.addr[AW-1:0]] = bus.wdata;
      end else if (bus.addr == sst_pkg::REG_ACC) begin
        s_next.acc = bus.wdata;
      end else if (bus.addr == sst_pkg::REG_STATUS) begin
        s_next.status = bus.wdata[5:0];
      end else if (bus.addr == sst_pkg::REG_TABLE_POINTER_LOW) begin
        s_next.table_pointer_low = bus.wdata;
      end else if (bus.addr == sst_pkg::REG_TABLE_POINTER_HIGH) begin
        s_next.table_pointer_high = bus.wdata;
      end else if (bus.addr == sst_pkg::REG_TABLE_HIGH_LATCH) begin
        s_next.table_high_latch = bus.wdata;
      end
    end

    unique case (s_reg.fsm)
      sst_pkg::SST_IDLE: begin
        if (take) begin
          unique case (ins.op)
            sst_pkg::SST_INCREMENT_SKIP_ZERO: begin
              s_next.mem[idx] = opnd + sst_pkg::ONE_BYTE;
              do_skip = (opnd + sst_pkg::ONE_BYTE) == sst_pkg::ZERO_BYTE;
            end
            sst_pkg::SST_INCREMENT_TO_ACCUM_SKIP_ZERO: begin
              s_next.acc = opnd + sst_pkg::ONE_BYTE;
              do_skip = (opnd + sst_pkg::ONE_BYTE) == sst_pkg::ZERO_BYTE;
            end
            sst_pkg::SST_SKIP_NONZERO: begin
              do_skip = (opnd != sst_pkg::ZERO_BYTE);
            end
            sst_pkg::SST_SKIP_NONZERO_BIT: begin
              do_skip = opnd_bit;
            end
            sst_pkg::SST_SKIP_IF_ZERO: begin
              do_skip = (opnd == sst_pkg::ZERO_BYTE);
            end
            sst_pkg::SST_SKIP_IF_ZERO_BIT: begin
              do_skip = ~opnd_bit;
            end
            sst_pkg::SST_COPY_AND_SKIP_ZERO: begin
              s_next.acc = opnd;
              do_skip = (opnd == sst_pkg::ZERO_BYTE);
            end
            sst_pkg::SST_SUB: begin
              {s_next.status, s_next.acc} = sr;
            end
            sst_pkg::SST_MINUS_INTO_MEMORY: begin
              {s_next.status, s_next.mem[idx]} = sr;
            end
            sst_pkg::SST_SUB_IMM: begin
              {s_next.status, s_next.acc} = sub_f(s_reg.acc, ins.imm);
            end
            sst_pkg::SST_NIBBLE_EXCHANGE: begin
              s_next.mem[idx] = opnd_swap;
            end
            sst_pkg::SST_NIBBLE_EXCHANGE_TO_ACCUM: begin
              s_next.acc = opnd_swap;
            end
            sst_pkg::SST_TABLE_READ_PAGED: begin
              is_tab = 1'b1;
              s_next.prog_addr = {s_reg.table_pointer_high, tp};
            end
            sst_pkg::SST_TABLE_READ_LAST_PAGE: begin
              is_tab = 1'b1;
              s_next.prog_addr = {sst_pkg::LAST_PAGE, tp};
            end
            sst_pkg::SST_PREINCREMENT_TABLE_READ: begin
              is_tab = 1'b1;
              tp = s_reg.table_pointer_low + sst_pkg::ONE_BYTE;
              s_next.table_pointer_low = tp;
              s_next.prog_addr = {s_reg.table_pointer_high, tp};
            end
            sst_pkg::SST_PREINCREMENT_TABLE_READ_LAST: begin
              is_tab = 1'b1;
              tp = s_reg.table_pointer_low + sst_pkg::ONE_BYTE;
              s_next.table_pointer_low = tp;
              s_next.prog_addr = {sst_pkg::LAST_PAGE, tp};
            end
            sst_pkg::SST_XOR: begin
              s_next.acc = xor_val;
              s_next.status[sst_pkg::FLAG_Z] = (xor_val == sst_pkg::ZERO_BYTE);
            end
            sst_pkg::SST_XOR_INTO_MEMORY: begin
              s_next.mem[idx] = xor_val;
              s_next.status[sst_pkg::FLAG_Z] = (xor_val == sst_pkg::ZERO_BYTE);
            end
            sst_pkg::SST_XOR_IMM: begin
              s_next.acc = s_reg.acc ^ ins.imm;
              s_next.status[sst_pkg::FLAG_Z] = ((s_reg.acc ^ ins.imm) == sst_pkg::ZERO_BYTE);
            end
            default: begin
            end
          endcase
          s_next.dst = idx;
          s_next.skip = do_skip;
          s_next.prog_rd = is_tab;
          s_next.done = ~do_skip && ~is_tab;
          if (do_skip) begin
            s_next.fsm = sst_pkg::SST_DUMMY;
          end else if (is_tab) begin
            s_next.fsm = sst_pkg::SST_TABLE;
          end
        end
      end
      sst_pkg::SST_DUMMY: begin
        // The discarded instruction is fetched during this cycle, so nothing executes.
        s_next.fsm = sst_pkg::SST_IDLE;
        s_next.done = 1'b1;
      end
      sst_pkg::SST_TABLE: begin
        s_next.mem[s_reg.dst] = prog_data[7:0];
        s_next.table_high_latch = prog_data[15:8];
        s_next.fsm = sst_pkg::SST_IDLE;
        s_next.done = 1'b1;
      end
      default: begin
        s_next.fsm = sst_pkg::SST_IDLE;
      end
    endcase
    s_next.busy = (s_next.fsm != sst_pkg::SST_IDLE);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
      s_reg.fsm <= sst_pkg::SST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
  assign prog_addr = s_reg.prog_addr;
  assign prog_rd = s_reg.prog_rd;
  assign busy = s_reg.busy;
  assign done = s_reg.done;
  assign skip_taken = s_reg.skip;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // A sequence rather than a function, so that every operand is taken at its sampled value on the edge.
  sequence is_op(sst_pkg::sst_op_type o);
    take && (ins.op == o) && !bus.wr;
  endsequence

  sequence dummy_then_done;
    busy && !done ##1 done && !busy;
  endsequence

  sequence table_fetch;
    prog_rd && busy ##1 done && !prog_rd;
  endsequence

  a_inc_skip_zero: assert property (is_op(sst_pkg::SST_INCREMENT_SKIP_ZERO) |=>
    skip_taken == ($past(opnd) == 8'hFF) && $stable(s_reg.status))
    else $error("increment skip decision wrong");
  a_skip_dummy: assert property (skip_taken |-> dummy_then_done)
    else $error("taken skip lacks one dummy cycle");
  a_inca_keep_mem: assert property (is_op(sst_pkg::SST_INCREMENT_TO_ACCUM_SKIP_ZERO) |=>
    s_reg.acc == $past(opnd) + 8'h01 && s_reg.mem == $past(s_reg.mem))
    else $error("increment to accumulator wrong");
  a_bit_zero_skip: assert property (is_op(sst_pkg::SST_SKIP_IF_ZERO_BIT) |=> skip_taken == !$past(opnd_bit))
    else $error("bit test skip wrong");
  a_copy_skip: assert property (is_op(sst_pkg::SST_COPY_AND_SKIP_ZERO) |=>
    s_reg.acc == $past(opnd) && skip_taken == (s_reg.acc == 8'h00))
    else $error("copy and skip wrong");
  a_sub_carry: assert property (is_op(sst_pkg::SST_SUB) |=> s_reg.acc == $past(acc_minus) &&
    s_reg.status[sst_pkg::FLAG_C] == ($past(s_reg.acc) >= $past(opnd)))
    else $error("subtract result or carry wrong");
  a_minus_into_memory_keep_acc: assert property (is_op(sst_pkg::SST_MINUS_INTO_MEMORY) |=>
    $stable(s_reg.acc) && s_reg.mem[s_reg.dst] == $past(acc_minus) && done)
    else $error("subtract to memory wrong");
  a_swap_accum: assert property (is_op(sst_pkg::SST_NIBBLE_EXCHANGE_TO_ACCUM) |=>
    s_reg.acc == $past(opnd_swap) && $stable(s_reg.mem))
    else $error("swap to accumulator wrong");
  a_table_last: assert property (is_op(sst_pkg::SST_PREINCREMENT_TABLE_READ_LAST) |=>
    prog_addr == {8'hFF, s_reg.table_pointer_low} && s_reg.table_pointer_low == $past(s_reg.table_pointer_low) + 8'h01 ##0 table_fetch)
    else $error("last page table read wrong");
  a_table_latch: assert property (s_reg.fsm == sst_pkg::SST_TABLE |=>
    s_reg.table_high_latch == $past(prog_data[15:8]))
    else $error("table high latch not loaded");
  a_xor_zero_only: assert property (is_op(sst_pkg::SST_XOR) |=> s_reg.acc == $past(xor_val) &&
    s_reg.status[sst_pkg::FLAG_Z] == (s_reg.acc == 8'h00) && s_reg.status[1:0] == $past(s_reg.status[1:0]))
    else $error("xor result or flags wrong");

  a_inc_mem_write: assert property (is_op(sst_pkg::SST_INCREMENT_SKIP_ZERO) |=>
    s_reg.mem[s_reg.dst] == $past(opnd) + 8'h01)
    else $error("increment skip write back wrong");
  a_inca_skip: assert property (is_op(sst_pkg::SST_INCREMENT_TO_ACCUM_SKIP_ZERO) |=>
    skip_taken == (s_reg.acc == 8'h00) && $stable(s_reg.status))
    else $error("increment to accumulator skip wrong");
  a_nz_byte_skip: assert property (is_op(sst_pkg::SST_SKIP_NONZERO) |=>
    skip_taken == ($past(opnd) != 8'h00) && $stable(s_reg.status))
    else $error("nonzero byte skip wrong");
  a_nz_bit_skip: assert property (is_op(sst_pkg::SST_SKIP_NONZERO_BIT) |=> skip_taken == $past(opnd[ins.bit_sel]))
    else $error("nonzero bit skip wrong");
  a_zero_byte_skip: assert property (is_op(sst_pkg::SST_SKIP_IF_ZERO) |=>
    skip_taken == ($past(opnd) == 8'h00) && $stable(s_reg.mem) && $stable(s_reg.status))
    else $error("zero byte skip wrong");
  a_sub_imm: assert property (is_op(sst_pkg::SST_SUB_IMM) |=> s_reg.acc == $past(s_reg.acc) - $past(ins.imm) &&
    s_reg.status[sst_pkg::FLAG_C] == ($past(s_reg.acc) >= $past(ins.imm)))
    else $error("subtract immediate wrong");
  a_sub_sign_flags: assert property (is_op(sst_pkg::SST_SUB) |=>
    s_reg.status[sst_pkg::FLAG_OV] ==
    (($past(s_reg.acc[7]) != $past(opnd[7])) && (s_reg.acc[7] != $past(s_reg.acc[7]))) &&
    s_reg.status[sst_pkg::FLAG_SC] == (s_reg.acc[7] ^ s_reg.status[sst_pkg::FLAG_OV]))
    else $error("subtract sign flags wrong");
  a_sub_half_zero: assert property (is_op(sst_pkg::SST_MINUS_INTO_MEMORY) |=>
    s_reg.status[sst_pkg::FLAG_AC] == ($past(s_reg.acc[3:0]) >= $past(opnd[3:0])) &&
    s_reg.status[sst_pkg::FLAG_Z] == (s_reg.mem[s_reg.dst] == 8'h00) &&
    s_reg.status[sst_pkg::FLAG_CZ] == s_reg.status[sst_pkg::FLAG_Z])
    else $error("subtract half carry or zero wrong");
  a_swap_mem: assert property (is_op(sst_pkg::SST_NIBBLE_EXCHANGE) |=>
    s_reg.mem[s_reg.dst] == {$past(opnd[3:0]), $past(opnd[7:4])} && $stable(s_reg.status))
    else $error("nibble swap in place wrong");
  a_table_paged: assert property (is_op(sst_pkg::SST_TABLE_READ_PAGED) |=>
    prog_addr == {s_reg.table_pointer_high, s_reg.table_pointer_low} && $stable(s_reg.table_pointer_low) ##0 table_fetch)
    else $error("paged table read wrong");
  a_table_lastpage: assert property (is_op(sst_pkg::SST_TABLE_READ_LAST_PAGE) |=>
    prog_addr == {8'hFF, s_reg.table_pointer_low} && $stable(s_reg.table_pointer_low))
    else $error("last page table address wrong");
  a_table_preinc: assert property (is_op(sst_pkg::SST_PREINCREMENT_TABLE_READ) |=>
    prog_addr == {s_reg.table_pointer_high, s_reg.table_pointer_low} && s_reg.table_pointer_low == $past(s_reg.table_pointer_low) + 8'h01)
    else $error("pre-increment table read wrong");
  a_table_low_byte: assert property (s_reg.fsm == sst_pkg::SST_TABLE |=>
    s_reg.mem[s_reg.dst] == $past(prog_data[7:0]))
    else $error("table low byte not stored");
  a_xor_into_memory_zero_only: assert property (is_op(sst_pkg::SST_XOR_INTO_MEMORY) |=> $stable(s_reg.acc) &&
    s_reg.mem[s_reg.dst] == ($past(s_reg.acc) ^ $past(opnd)) &&
    s_reg.status[1:0] == $past(s_reg.status[1:0]) &&
    s_reg.status[sst_pkg::FLAG_Z] == (s_reg.mem[s_reg.dst] == 8'h00))
    else $error("xor to memory wrong");
  a_xor_imm: assert property (is_op(sst_pkg::SST_XOR_IMM) |=>
    s_reg.acc == ($past(s_reg.acc) ^ $past(ins.imm)) && s_reg.status[sst_pkg::FLAG_Z] == (s_reg.acc == 8'h00) &&
    s_reg.status[5:3] == $past(s_reg.status[5:3]) && s_reg.status[1:0] == $past(s_reg.status[1:0]))
    else $error("xor immediate wrong");

endmodule : sst_exec

//--- bench/sst_exec_tb.sv
// Purpose: Self-checking bench for the skip, subtract, swap, table-read and XOR execution core.
// Assumes: Default DEPTH of 64; program memory is modelled as a fixed function of the word address.
// Notes: Every access and every instruction but the one held through the dummy cycle is issued through shared tasks; expectations are computed here.
`timescale 1ns/10ps

module sst_exec_tb;

  // ****************************************
  // Signals and stimulus tables
  // ****************************************
  logic clk;
  logic sys_rst;
  logic ins_valid;
  sst_pkg::sst_instr_type ins;
  sst_pkg::sst_bus_type bus;
  logic [7:0] rdata;
  logic [15:0] prog_addr;
  logic prog_rd;
  logic [15:0] prog_data;
  logic busy;
  logic done;
  logic skip_taken;
  int fail_count = 0;
  int num_checks = 0;
  logic [15:0] exp;
  sst_pkg::sst_op_type sk_op[8] = '{sst_pkg::SST_SKIP_NONZERO, sst_pkg::SST_SKIP_NONZERO,
    sst_pkg::SST_SKIP_NONZERO_BIT, sst_pkg::SST_SKIP_NONZERO_BIT, sst_pkg::SST_SKIP_IF_ZERO,
    sst_pkg::SST_SKIP_IF_ZERO, sst_pkg::SST_SKIP_IF_ZERO_BIT, sst_pkg::SST_SKIP_IF_ZERO_BIT};
  logic [7:0] sk_adr[8] = '{8'h05, 8'h06, 8'h05, 8'h05, 8'h05, 8'h06, 8'h05, 8'h05};
  logic [2:0] sk_bit[8] = '{3'h0, 3'h0, 3'h4, 3'h3, 3'h0, 3'h0, 3'h3, 3'h4};
  logic sk_exp[8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  sst_pkg::sst_op_type sub_ops[3] = '{sst_pkg::SST_SUB, sst_pkg::SST_MINUS_INTO_MEMORY, sst_pkg::SST_SUB_IMM};
  logic [7:0] av[3] = '{8'h50, 8'h80, 8'h33};
  logic [7:0] bv[3] = '{8'h70, 8'h01, 8'h33};
  sst_pkg::sst_op_type tops[5] = '{sst_pkg::SST_TABLE_READ_PAGED, sst_pkg::SST_TABLE_READ_LAST_PAGE,
    sst_pkg::SST_PREINCREMENT_TABLE_READ, sst_pkg::SST_PREINCREMENT_TABLE_READ_LAST,
    sst_pkg::SST_PREINCREMENT_TABLE_READ};
  logic [7:0] tlp[5] = '{8'h10, 8'h10, 8'h10, 8'hFF, 8'hFF};
  logic [15:0] tpa[5] = '{16'h0210, 16'hFF10, 16'h0211, 16'hFF00, 16'h0200};

  // Distinct patterns in both halves catch a swapped or shifted word split.
  assign prog_data = {prog_addr[15:8] ^ 8'h5A, prog_addr[7:0] ^ 8'hC3};

  sst_exec DUT (.clk(clk), .sys_rst(sys_rst), .ins_valid(ins_valid), .ins(ins), .bus(bus), .rdata(rdata),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data), .busy(busy), .done(done),
    .skip_taken(skip_taken));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict();
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    check(rdata, want);
  endtask : bus_rd

  // Issues one instruction and checks the cycle shape: plain ops finish at once, skips and table reads take two.
  task automatic exec(input sst_pkg::sst_op_type op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] imm,
                      input logic sk, input logic tb, input logic [15:0] pa);
    @(posedge clk);
    ins <= '{op: op, addr: a, bit_sel: b, imm: imm};
    ins_valid <= 1'b1;
    @(posedge clk);
    ins_valid <= 1'b0;
    #1;
    check(skip_taken, sk);
    check({prog_rd, busy, done}, {tb, sk | tb, ~(sk | tb)});
    if (tb) check(prog_addr, pa);
    if (sk | tb) begin
      @(posedge clk);
      #1;
      check({busy, done}, 2'b01);
    end
  endtask : exec

  function automatic logic [15:0] sub_model(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] d;
    logic ov;
    logic z;
    d = {1'b0, a} - {1'b0, b};
    ov = (a[7] ^ b[7]) & (a[7] ^ d[7]);
    z = (d[7:0] == 8'h00);
    return {2'b00, z, ov ^ d[7], ov, z, a[3:0] >= b[3:0], ~d[8], d[7:0]};
  endfunction : sub_model

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    ins_valid = 1'b0;
    ins = '0;
    bus = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    bus_rd(sst_pkg::REG_ACC, 8'h00);
    bus_rd(sst_pkg::REG_STATUS, 8'h00);
    bus_wr(8'h50, 8'hAA);
    bus_rd(8'h50, 8'h00);
    bus_wr(sst_pkg::REG_STATUS, 8'hFF);
    bus_rd(sst_pkg::REG_STATUS, 8'h3F);
    bus_wr(sst_pkg::REG_STATUS, 8'h15);
    bus_wr(8'h03, 8'hFF);
    exec(sst_pkg::SST_INCREMENT_SKIP_ZERO, 8'h03, 3'h0, 8'h00, 1'b1, 1'b0, 16'h0000);
    bus_rd(8'h03, 8'h00);
    bus_wr(8'h03, 8'h05);
    exec(sst_pkg::SST_INCREMENT_SKIP_ZERO, 8'h03, 3'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
    bus_rd(8'h03, 8'h06);
    // An instruction held through the dummy cycle must be ignored, so the byte is bumped only once.
    bus_wr(8'h03, 8'hFF);
    @(posedge clk);
    ins <= '{op: sst_pkg::SST_INCREMENT_SKIP_ZERO, addr: 8'h03, bit_sel: 3'h0, imm: 8'h00};
    ins_valid <= 1'b1;
    repeat (2) @(posedge clk);
    ins_valid <= 1'b0;
    @(posedge clk);
    bus_rd(8'h03, 8'h00);
    bus_wr(8'h04, 8'hFF);
    exec(sst_pkg::SST_INCREMENT_TO_ACCUM_SKIP_ZERO, 8'h04, 3'h0, 8'h00, 1'b1, 1'b0, 16'h0000);
    bus_rd(sst_pkg::REG_ACC, 8'h00);
    bus_rd(8'h04, 8'hFF);
    bus_wr(8'h05, 8'h10);
    bus_wr(8'h06, 8'h00);
    for (int j = 0; j < 8; j++) begin
      exec(sk_op[j], sk_adr[j], sk_bit[j], 8'h00, sk_exp[j], 1'b0, 16'h0000);
    end
    bus_rd(8'h05, 8'h10);
    exec(sst_pkg::SST_COPY_AND_SKIP_ZERO, 8'h06, 3'h0, 8'h00, 1'b1, 1'b0, 16'h0000);
    bus_rd(sst_pkg::REG_ACC, 8'h00);
    exec(sst_pkg::SST_COPY_AND_SKIP_ZERO, 8'h05, 3'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
    bus_rd(sst_pkg::REG_ACC, 8'h10);
    bus_wr(8'h09, 8'h3C);
    exec(sst_pkg::SST_NIBBLE_EXCHANGE, 8'h09, 3'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
    bus_rd(8'h09, 8'hC3);
    exec(sst_pkg::SST_NIBBLE_EXCHANGE_TO_ACCUM, 8'h09, 3'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
    bus_rd(sst_pkg::REG_ACC, 8'h3C);
    bus_rd(8'h09, 8'hC3);
    bus_rd(sst_pkg::REG_STATUS, 8'h15);
    for (int k = 0; k < 3; k++) begin
      for (int j = 0; j < 3; j++) begin
        exp = sub_model(av[j], bv[j]);
        bus_wr(sst_pkg::REG_ACC, av[j]);
        bus_wr(8'h08, bv[j]);
        exec(sub_ops[k], 8'h08, 3'h0, bv[j], 1'b0, 1'b0, 16'h0000);
        bus_rd(sst_pkg::REG_ACC, (k == 1) ? av[j] : exp[7:0]);
        bus_rd(8'h08, (k == 1) ? exp[7:0] : bv[j]);
        bus_rd(sst_pkg::REG_STATUS, exp[15:8]);
      end
    end
    bus_wr(sst_pkg::REG_STATUS, 8'h3B);
    bus_wr(sst_pkg::REG_ACC, 8'h5A);
    bus_wr(8'h0A, 8'h5A);
    exec(sst_pkg::SST_XOR, 8'h0A, 3'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
    bus_rd(sst_pkg::REG_ACC, 8'h00);
    bus_rd(sst_pkg::REG_STATUS, 8'h3F);
    exec(sst_pkg::SST_XOR_IMM, 8'h0A, 3'h0, 8'h0F, 1'b0, 1'b0, 16'h0000);
    bus_rd(sst_pkg::REG_ACC, 8'h0F);
    bus_rd(sst_pkg::REG_STATUS, 8'h3B);
    bus_wr(sst_pkg::REG_ACC, 8'h5A);
    exec(sst_pkg::SST_XOR_INTO_MEMORY, 8'h0A, 3'h0, 8'h00, 1'b0, 1'b0, 16'h0000);
    bus_rd(8'h0A, 8'h00);
    bus_rd(sst_pkg::REG_ACC, 8'h5A);
    bus_rd(sst_pkg::REG_STATUS, 8'h3F);
    bus_wr(sst_pkg::REG_STATUS, 8'h15);
    bus_wr(sst_pkg::REG_TABLE_POINTER_HIGH, 8'h02);
    for (int j = 0; j < 5; j++) begin
      bus_wr(sst_pkg::REG_TABLE_POINTER_LOW, tlp[j]);
      exec(tops[j], 8'h0C, 3'h0, 8'h00, 1'b0, 1'b1, tpa[j]);
      bus_rd(8'h0C, tpa[j][7:0] ^ 8'hC3);
      bus_rd(sst_pkg::REG_TABLE_HIGH_LATCH, tpa[j][15:8] ^ 8'h5A);
      bus_rd(sst_pkg::REG_TABLE_POINTER_LOW, tpa[j][7:0]);
      bus_rd(sst_pkg::REG_TABLE_POINTER_HIGH, 8'h02);
    end
    bus_rd(sst_pkg::REG_STATUS, 8'h15);
    give_verdict();
  end

  // A hang anywhere ends the run as a failure.
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end

endmodule : sst_exec_tb
